// [rtl/dts_pkg.sv]
package dts_pkg;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int CLK_HZ = 200_000_000;
	localparam int COAST_DROP_MS = 100;
	localparam int COAST_PRE_START_MS = 50;
	// longest time rounds down
	localparam int COAST_DROP_CYC = (CLK_HZ / 1000) * COAST_DROP_MS;
	// least time also rounds down
	localparam int COAST_PRE_START_CYC = (CLK_HZ / 1000) * COAST_PRE_START_MS;

	// ------------------------------------------------------------
	// data widths and reset values
	// ------------------------------------------------------------
	localparam int VAL_W = 16;
	localparam logic signed [VAL_W-1:0] POT_PRESET_VAL = 16'sh0000;
	localparam logic signed [VAL_W-1:0] ZERO_VAL = 16'sh0000;

	typedef logic signed [VAL_W-1:0] dts_val_t;

	// terminal digital inputs travel together
	typedef struct packed {
		logic run;
		logic jog;
		logic start;
		logic coast_stop;
		logic jog_speed_select;
		logic ramp_hold;
		logic dual_clamp_enable;
		logic zero_ref_interlock;
		logic pot_preset_enable;
		logic pot_increase;
		logic pot_decrease;
	} dts_term_t;

	// status flags out to the terminals
	typedef struct packed {
		logic zero_speed_flag;
		logic ramping_flag;
		logic healthy_flag;
		logic contactor;
		logic loops_enable;
		logic field_enable;
	} dts_flags_t;

	// programmed setpoints
	typedef struct packed {
		dts_val_t jog_speed_1;
		dts_val_t jog_speed_2;
		dts_val_t crawl_speed;
		dts_val_t zero_interlock_threshold;
		dts_val_t run_ramp_fwd_step;
		dts_val_t run_ramp_rev_step;
		dts_val_t stop_ramp_step;
		dts_val_t jog_ramp_step;
		dts_val_t pot_step;
	} dts_cfg_t;

endpackage : dts_pkg

// [rtl/dts_sequencer.sv]
// Summary of operation
// RL1: preset enable forces pot output to preset
// RL2: otherwise pot moves by increase/decrease inputs
// RL3: interlock blocks contactor until reference near zero
// RL4: jog select low speed 1, high speed 2
// RL5: ramp hold freezes run ramp output
// RL6: dual clamp selects symmetric or split limits
// RL7: positive upper clamp limits, negative drives demand
// RL8: zero speed flag high below threshold
// RL9: ramping flag high while run ramp changes
// RL10: healthy only without alarm and ready
// RL11: run low inhibits loops and field
// RL12: run low drops held contactor at once
// RL13: jog without start jogs, ramps down after
// RL14: start needs no alarm, coast, run, no jog
// RL15: start removed ramps to zero, then contactor off
// RL16: jog rising during start gives slack take-up; code does this in run only, jog is ignored in crawl
// RL17: start rising with select high gives crawl
// RL18: coast stop low drops contactor within 100 ms
// RL19: coast stop high 50 ms before start
// RL20: all terminals sampled on the system clock
`timescale 1ns/1ps
`default_nettype none

module dts_sequencer #(
	parameter int COAST_DROP_CYCLES = dts_pkg::COAST_DROP_CYC,
	parameter int COAST_READY_CYCLES = dts_pkg::COAST_PRE_START_CYC
) (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire dts_pkg::dts_term_t term_in,
	input wire dts_pkg::dts_cfg_t cfg,
	input wire logic alarm,
	input wire dts_pkg::dts_val_t ramped_ref_input,
	input wire dts_pkg::dts_val_t speed_ref,
	input wire dts_pkg::dts_val_t speed_feedback,
	input wire dts_pkg::dts_val_t speed_loop_demand,
	input wire dts_pkg::dts_val_t upper_clamp_input,
	input wire dts_pkg::dts_val_t lower_clamp_input,
	output dts_pkg::dts_flags_t flags,
	output dts_pkg::dts_val_t pot_output,
	output dts_pkg::dts_val_t ramp_output,
	output dts_pkg::dts_val_t seq_speed_ref,
	output dts_pkg::dts_val_t current_demand,
	output dts_pkg::dts_val_t pos_clamp,
	output dts_pkg::dts_val_t neg_clamp
);
	import dts_pkg::*;

	if (COAST_DROP_CYCLES < 2 || COAST_READY_CYCLES < 1) begin : g_bad_counts
		$error("coast stop counts too small");
	end

	typedef enum {ST_IDLE, ST_RUN, ST_CRAWL, ST_JOG, ST_STOP} dts_state_t;

	// ------------------------------------------------------------
	// input sampling
	// ------------------------------------------------------------
	dts_term_t t_r;
	dts_term_t t_prev_r;
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			t_r <= '0;
			t_prev_r <= '0;
		end else begin
			t_r <= term_in; // see RL20
			t_prev_r <= t_r;
		end
	end

	wire logic start_rise = t_r.start && !t_prev_r.start;
	// slack take-up needs no edge detector: run is only entered with jog low

	// ------------------------------------------------------------
	// coast stop timing
	// ------------------------------------------------------------
	localparam int CW = $clog2(COAST_DROP_CYCLES + COAST_READY_CYCLES + 1);
	logic [CW-1:0] coast_hi_cnt_r;
	// no low-side counter: the drop limit is met by reacting to the first low sample
	wire logic coast_ready = coast_hi_cnt_r >= CW'(COAST_READY_CYCLES);
	// drop well inside the limit: first sampled low cycle already ends running
	wire logic coast_drop = !t_r.coast_stop; // see RL18
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			coast_hi_cnt_r <= '0;
		end else begin
			if (!t_r.coast_stop)
				coast_hi_cnt_r <= '0;
			else if (!coast_ready)
				coast_hi_cnt_r <= coast_hi_cnt_r + 1'b1;
		end
	end

	// ------------------------------------------------------------
	// sequencing
	// ------------------------------------------------------------
	dts_state_t state_r;
	dts_state_t state_nxt;
	logic contactor_r;
	logic contactor_nxt;
	logic interlock_ok_r;
	dts_val_t seq_ref_r;
	dts_val_t seq_ref_nxt;

	wire logic at_zero = (speed_feedback < cfg.zero_interlock_threshold)
		&& (speed_feedback > -cfg.zero_interlock_threshold);
	wire logic ref_low = (speed_ref < cfg.zero_interlock_threshold)
		&& (speed_ref > -cfg.zero_interlock_threshold);
	wire logic ready = !alarm && t_r.coast_stop && coast_ready && t_r.run;
	wire dts_val_t jog_speed = t_r.jog_speed_select ?
		cfg.jog_speed_2 : cfg.jog_speed_1; // see RL4
	wire logic start_ok = ready && !t_r.jog && t_r.start; // see RL14
	wire logic energise_ok = !t_r.zero_ref_interlock || interlock_ok_r; // see RL3

	// ramp one step toward a target
	function automatic dts_val_t step_to(input dts_val_t cur, input dts_val_t tgt,
		input dts_val_t stp);
		dts_val_t d;
		d = dts_val_t'(tgt - cur);
		if (d > stp)
			step_to = dts_val_t'(cur + stp);
		else if (d < -stp)
			step_to = dts_val_t'(cur - stp);
		else
			step_to = tgt;
	endfunction : step_to

	always_comb begin
		state_nxt = state_r;
		contactor_nxt = contactor_r;
		seq_ref_nxt = seq_ref_r;
		case (state_r)
			ST_IDLE: begin
				seq_ref_nxt = ZERO_VAL;
				if (start_ok && energise_ok) begin
					state_nxt = (start_rise && t_r.jog_speed_select) ? ST_CRAWL : ST_RUN; // see RL17
					contactor_nxt = 1'b1;
				end else if (ready && t_r.jog && !t_r.start && energise_ok) begin
					state_nxt = ST_JOG; // see RL13
					contactor_nxt = 1'b1;
				end
			end
			ST_RUN: begin
				// slack take-up while jog held
				if (t_r.jog)
					seq_ref_nxt = jog_speed; // see RL16
				else
					seq_ref_nxt = ramp_output;
				if (!t_r.start)
					state_nxt = ST_STOP; // see RL15
			end
			ST_CRAWL: begin
				seq_ref_nxt = step_to(seq_ref_r, cfg.crawl_speed, cfg.run_ramp_fwd_step); // see RL17
				if (!t_r.start)
					state_nxt = ST_STOP;
			end
			ST_JOG: begin
				if (t_r.jog)
					seq_ref_nxt = step_to(seq_ref_r, jog_speed, cfg.jog_ramp_step);
				else begin
					seq_ref_nxt = step_to(seq_ref_r, ZERO_VAL, cfg.jog_ramp_step); // see RL13
					// the jog ramp must reach zero before the contactor drops
					if (at_zero && seq_ref_nxt == ZERO_VAL) begin
						state_nxt = ST_IDLE;
						contactor_nxt = 1'b0;
					end
				end
			end
			ST_STOP: begin
				seq_ref_nxt = step_to(seq_ref_r, ZERO_VAL, cfg.stop_ramp_step);
				if (at_zero && seq_ref_nxt == ZERO_VAL) begin
					state_nxt = ST_IDLE;
					contactor_nxt = 1'b0; // see RL15
				end
			end
			default: state_nxt = ST_IDLE;
		endcase
		// run low or coast stop or alarm ends the sequence immediately: idle state, contactor off, reference zero
		if (!t_r.run || coast_drop || alarm) begin
			state_nxt = ST_IDLE; // see RL12
			contactor_nxt = 1'b0; // see RL18
			seq_ref_nxt = ZERO_VAL;
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			state_r <= ST_IDLE;
			contactor_r <= 1'b0;
			seq_ref_r <= ZERO_VAL;
			interlock_ok_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			contactor_r <= contactor_nxt;
			seq_ref_r <= seq_ref_nxt;
			// the reference must return near zero while idle before a new start
			if (contactor_r)
				interlock_ok_r <= 1'b0;
			else if (ref_low)
				interlock_ok_r <= 1'b1; // see RL3
		end
	end

	// ------------------------------------------------------------
	// motorised pot simulator
	// ------------------------------------------------------------
	dts_val_t pot_r;
	wire dts_val_t pot_up = dts_val_t'(pot_r + cfg.pot_step);
	wire dts_val_t pot_dn = dts_val_t'(pot_r - cfg.pot_step);
	wire logic pot_up_ok = pot_up > pot_r;
	wire logic pot_dn_ok = pot_dn < pot_r;
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn)
			pot_r <= POT_PRESET_VAL;
		else if (t_r.pot_preset_enable)
			pot_r <= POT_PRESET_VAL; // see RL1
		else if (t_r.pot_increase && !t_r.pot_decrease && pot_up_ok)
			pot_r <= pot_up; // see RL2
		else if (t_r.pot_decrease && !t_r.pot_increase && pot_dn_ok)
			pot_r <= pot_dn; // see RL2
	end

	// ------------------------------------------------------------
	// run mode ramp
	// ------------------------------------------------------------
	dts_val_t ramp_r;
	logic ramping_r;
	wire logic ramp_up_mag = (ramped_ref_input >= ZERO_VAL) ?
		(ramped_ref_input > ramp_r) : (ramped_ref_input < ramp_r);
	wire dts_val_t ramp_stp = ramp_up_mag ? cfg.run_ramp_fwd_step : cfg.run_ramp_rev_step;
	wire dts_val_t ramp_nxt = step_to(ramp_r, ramped_ref_input, ramp_stp);
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			ramp_r <= ZERO_VAL;
			ramping_r <= 1'b0;
		end else if (!t_r.run) begin
			ramp_r <= ZERO_VAL; // see RL11
			ramping_r <= 1'b0;
		end else if (t_r.ramp_hold) begin
			ramping_r <= 1'b0; // see RL5
		end else begin
			ramp_r <= ramp_nxt; // see RL5
			ramping_r <= ramp_nxt != ramp_r; // see RL9
		end
	end

	// ------------------------------------------------------------
	// current clamps
	// ------------------------------------------------------------
	wire logic upper_neg = upper_clamp_input < ZERO_VAL;
	wire dts_val_t upper_mag = upper_neg ? dts_val_t'(-upper_clamp_input) : upper_clamp_input;
	wire dts_val_t pos_lim = upper_mag;
	wire dts_val_t neg_lim = t_r.dual_clamp_enable ? lower_clamp_input :
		dts_val_t'(-upper_mag); // see RL6
	// negative upper input drives the demand and bypasses the speed loop
	wire dts_val_t raw_demand = upper_neg ? upper_clamp_input : speed_loop_demand; // see RL7
	wire dts_val_t clamped = (raw_demand > pos_lim) ? pos_lim :
		(raw_demand < neg_lim) ? neg_lim : raw_demand; // see RL7

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	dts_flags_t flags_r;
	dts_val_t demand_r;
	dts_val_t pos_r;
	dts_val_t neg_r;
	wire logic loops_on = t_r.run && contactor_r; // see RL11
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			flags_r <= '0;
			demand_r <= ZERO_VAL;
			pos_r <= ZERO_VAL;
			neg_r <= ZERO_VAL;
		end else begin
			flags_r.zero_speed_flag <= at_zero; // see RL8
			flags_r.ramping_flag <= ramping_r; // see RL9
			flags_r.healthy_flag <= ready; // see RL10
			flags_r.contactor <= contactor_nxt;
			flags_r.loops_enable <= loops_on; // see RL11
			flags_r.field_enable <= t_r.run; // see RL11
			demand_r <= loops_on ? clamped : ZERO_VAL;
			pos_r <= pos_lim;
			neg_r <= neg_lim;
		end
	end

	assign flags = flags_r;
	assign pot_output = pot_r;
	assign ramp_output = ramp_r;
	assign seq_speed_ref = seq_ref_r;
	assign current_demand = demand_r;
	assign pos_clamp = pos_r;
	assign neg_clamp = neg_r;

endmodule : dts_sequencer

`default_nettype wire

// [sim/dts_sequencer_checker.sv]
`timescale 1ns/1ps
`default_nettype none
module dts_sequencer_checker (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire dts_pkg::dts_term_t term_in,
	input wire dts_pkg::dts_cfg_t cfg,
	input wire dts_pkg::dts_val_t speed_feedback,
	input wire dts_pkg::dts_val_t upper_clamp_input,
	input wire dts_pkg::dts_flags_t flags,
	input wire dts_pkg::dts_val_t pot_output,
	input wire dts_pkg::dts_val_t ramp_output,
	input wire dts_pkg::dts_val_t current_demand,
	input wire dts_pkg::dts_val_t pos_clamp,
	input wire dts_pkg::dts_val_t neg_clamp
);
	import dts_pkg::*;
	wire logic slow = speed_feedback < cfg.zero_interlock_threshold
		&& speed_feedback > -cfg.zero_interlock_threshold;
	wire logic sym = !term_in.dual_clamp_enable && upper_clamp_input > 16'sh0000;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	chk_preset_to_zero:
	assert property (term_in.pot_preset_enable |-> ##2 pot_output == POT_PRESET_VAL)
		else $error("pot not preset");
	chk_run_drops_all:
	assert property (!term_in.run |-> ##2 !(flags.contactor | flags.loops_enable
		| flags.field_enable)) else $error("run low left drive on");
	chk_coast_drops:
	assert property (!term_in.coast_stop |-> ##2 !flags.contactor)
		else $error("coast low left contactor on");
	chk_start_qualified:
	assert property ($rose(flags.contactor) |-> $past(term_in.run, 2)
		&& $past(term_in.coast_stop, 2)) else $error("contactor without run and coast");
	chk_zero_flag_set:
	assert property (slow [*3] |-> flags.zero_speed_flag) else $error("zero speed missing");
	chk_sym_clamp:
	assert property (sym [*3] |-> pos_clamp == upper_clamp_input
		&& neg_clamp == -upper_clamp_input) else $error("symmetric clamp wrong");
	chk_demand_clamped:
	assert property (sym [*3] |-> current_demand <= pos_clamp && current_demand >= neg_clamp)
		else $error("demand beyond clamp");
	chk_hold_freezes:
	assert property ((term_in.ramp_hold && term_in.run) [*3] |=> $stable(ramp_output))
		else $error("ramp moved on hold");
	cover property ($rose(flags.contactor));
	cover property (flags.ramping_flag);
	cover property (sym ##1 term_in.ramp_hold);
endmodule : dts_sequencer_checker
bind dts_sequencer dts_sequencer_checker u_chk (.clk_sys, .rstn, .term_in, .cfg,
	.speed_feedback, .upper_clamp_input, .flags, .pot_output, .ramp_output,
	.current_demand, .pos_clamp, .neg_clamp);
`default_nettype wire

// [sim/dts_switch_model.sv]
`timescale 1ns/1ps
`default_nettype none
module dts_switch_model #(
	parameter int READY_CYCLES = 8
) (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire dts_pkg::dts_term_t want,
	output dts_pkg::dts_term_t term
);
	import dts_pkg::*;
	int coast_cnt_r;
	wire logic ready = coast_cnt_r >= READY_CYCLES;
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			coast_cnt_r <= 0;
		end else if (!want.coast_stop) begin
			coast_cnt_r <= 0;
		end else if (!ready) begin
			coast_cnt_r <= coast_cnt_r + 1;
		end
	end
	// start is withheld until the coast line has been up long enough
	always_comb begin
		term = want;
		term.start = want.start & ready;
	end
endmodule : dts_switch_model
`default_nettype wire

// [sim/test_dts_sequencer.sv]
`timescale 1ns/1ps
`default_nettype none
module test_dts_sequencer;
	import dts_pkg::*;
	logic clk_sys;
	logic rstn;
	logic alarm;
	dts_term_t want;
	dts_term_t term_in;
	dts_cfg_t cfg;
	dts_val_t rref, sref, fb, sld, upc, loc;
	dts_flags_t flags;
	dts_val_t pot_output, ramp_output, seq_speed_ref, current_demand, pos_clamp, neg_clamp;
	int n_errors = 0;
	int total_checks = 0;
	dts_sequencer #(.COAST_DROP_CYCLES(4), .COAST_READY_CYCLES(4)) uut (.clk_sys, .rstn,
		.term_in, .cfg, .alarm, .ramped_ref_input(rref), .speed_ref(sref), .speed_feedback(fb),
		.speed_loop_demand(sld), .upper_clamp_input(upc), .lower_clamp_input(loc), .flags,
		.pot_output, .ramp_output, .seq_speed_ref, .current_demand, .pos_clamp, .neg_clamp);
	dts_switch_model #(.READY_CYCLES(8)) u_sw (.clk_sys, .rstn, .want, .term(term_in));
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR %0t: saw %h want %h", $time, seen, exp);
		end
	endtask : check
	task automatic tick(input int n);
		repeat (n) @(negedge clk_sys);
	endtask : tick
	task automatic wait_ref(input dts_val_t v);
		repeat (100) if (seq_speed_ref !== v) tick(1);
		check(seq_speed_ref, v);
	endtask : wait_ref
	task automatic go_run();
		want.run = 1'b1;
		want.coast_stop = 1'b1;
		want.start = 1'b1;
		repeat (30) if (flags.contactor !== 1'b1) tick(1);
	endtask : go_run
	task automatic t_start();
		go_run();
		check(flags.contactor, 1'b1);
		tick(3);
		check(current_demand, 16'sh0064);
		fb = 16'sh03e8;
		want.start = 1'b0;
		tick(6);
		check(flags.contactor, 1'b1);
		fb = 16'sh0000;
		tick(4);
		check(flags.contactor, 1'b0);
		$display("start stop done");
	endtask : t_start
	task automatic t_drops();
		go_run();
		fb = 16'sh03e8;
		want.start = 1'b0;
		tick(4);
		want.run = 1'b0;
		tick(2);
		check(flags.contactor, 1'b0);
		check({flags.loops_enable, flags.field_enable}, 2'b00);
		want.run = 1'b1;
		fb = 16'sh0000;
		go_run();
		want.coast_stop = 1'b0;
		tick(2);
		check(flags.contactor, 1'b0);
		want.start = 1'b0;
		want.coast_stop = 1'b1;
		alarm = 1'b1;
		go_run();
		check(flags.contactor, 1'b0);
		check(flags.healthy_flag, 1'b0);
		alarm = 1'b0;
		want.start = 1'b0;
		tick(4);
		check(flags.healthy_flag, 1'b1);
		$display("drops done");
	endtask : t_drops
	task automatic t_modes();
		want.jog = 1'b1;
		wait_ref(cfg.jog_speed_1);
		want.jog_speed_select = 1'b1;
		wait_ref(cfg.jog_speed_2);
		want.jog = 1'b0;
		wait_ref(16'sh0000);
		go_run();
		wait_ref(cfg.crawl_speed);
		want.start = 1'b0;
		wait_ref(16'sh0000);
		want.jog_speed_select = 1'b0;
		tick(4);
		go_run();
		want.jog = 1'b1;
		wait_ref(cfg.jog_speed_1);
		want.jog = 1'b0;
		want.start = 1'b0;
		tick(10);
		$display("modes done");
	endtask : t_modes
	task automatic t_interlock();
		want.zero_ref_interlock = 1'b1;
		go_run();
		check(flags.contactor, 1'b1);
		sref = 16'sh012c;
		want.start = 1'b0;
		tick(4);
		check(flags.contactor, 1'b0);
		go_run();
		check(flags.contactor, 1'b0);
		sref = 16'sh0000;
		tick(3);
		check(flags.contactor, 1'b1);
		want.start = 1'b0;
		want.zero_ref_interlock = 1'b0;
		tick(4);
		$display("interlock done");
	endtask : t_interlock
	task automatic t_misc();
		want.pot_increase = 1'b1;
		tick(4);
		check(pot_output > 16'sh0000, 1'b1);
		want.pot_preset_enable = 1'b1;
		tick(3);
		check(pot_output, POT_PRESET_VAL);
		want.pot_preset_enable = 1'b0;
		want.pot_increase = 1'b0;
		fb = 16'sh03e8;
		tick(4);
		check(flags.zero_speed_flag, 1'b0);
		fb = 16'sh0000;
		want.ramp_hold = 1'b1;
		tick(4);
		check(flags.zero_speed_flag, 1'b1);
		check(neg_clamp, 16'shff9c);
		want.dual_clamp_enable = 1'b1;
		tick(4);
		check(neg_clamp, 16'shffce);
		check(pos_clamp, 16'sh0064);
		want.ramp_hold = 1'b0;
		rref = 16'sh03e8;
		tick(3);
		check(ramp_output, 16'sh00c8);
		check(flags.ramping_flag, 1'b1);
		want.ramp_hold = 1'b1;
		tick(4);
		check(ramp_output, 16'sh012c);
		check(flags.ramping_flag, 1'b0);
		want.ramp_hold = 1'b0;
		tick(12);
		check(ramp_output, 16'sh03e8);
		check(flags.ramping_flag, 1'b0);
		upc = 16'shffce;
		go_run();
		tick(2);
		check(current_demand, 16'shffce);
		check(pos_clamp, 16'sh0032);
		$display("misc done");
	endtask : t_misc
	task automatic report_and_stop();
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : report_and_stop
	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end
	initial begin
		rstn = 1'b0;
		alarm = 1'b0;
		want = '0;
		cfg = {16'sh00c8, 16'sh0190, 16'sh0096, 16'sh0032, 16'sh0064, 16'sh0064, 16'sh0064,
			16'sh0064, 16'sh000a};
		rref = 16'sh0000;
		sref = 16'sh0000;
		fb = 16'sh0000;
		sld = 16'sh03e8;
		upc = 16'sh0064;
		loc = 16'shffce;
		tick(8);
		rstn = 1'b1;
		t_start();
		t_drops();
		t_modes();
		t_interlock();
		t_misc();
		report_and_stop();
	end
	initial begin
		#20000;
		n_errors++;
		report_and_stop();
	end
endmodule : test_dts_sequencer
`default_nettype wire
